// ---- core/durd_regs.sv ----
`timescale 1ns/1ns
// Functional notes
// - each channel has own registers; three address lines pick, channel select picks channel
// - address 0, divisor latch off: read receive holding, write transmit holding
// - divisor latch on, line control not 0xBF: addresses 0,1 are divisor bytes
// - divisor latch, enhanced off: address 2 is alternate function register
// - divisor latch, enhanced on: address 2 is fractional divisor register
// - divisor bytes both zero: addresses 0,1 read revision and device id
// - latch off: address 1 interrupt enable; address 2 reads status, writes fifo control
// - line control not 0xBF: addresses 3..7 line, modem control, status, scratch
// - line control 0xBF: address 2 enhanced feature, 4..7 resume and pause chars
// - upper enhanced bits are written only with enhanced enable, else read as zero
// - interrupt enable bit layout, low four standard, upper four enhanced
// - interrupt status bits 5:0 source code, bits 7:6 fifos enabled
// - fifo control: enable, rx reset, tx reset, dma, tx and rx triggers
// - line control: word length, stop, parity enable, even, forced, break, latch
// - modem control: dtr, rts, out1, out2, loopback; enhanced resume-any, infrared, prescaler
// - line status: ready, overrun, parity, framing, break, thr empty, all empty, fifo error
// - modem status: four change flags low, four current input states high
// - alternate function: concurrent write, baud-clock output, receive-ready output; 7:3 reserved
// - fractional divisor: fraction 3:0, 8x bit 4, 4x bit 5, 7:6 read zero
`include "durd_params.svh"
module durd_regs (
  input  wire logic       clk,
  input  wire logic       srst,
  // host bus, same clock domain
  input  wire logic       chan_sel,
  input  wire logic       chan_id,
  input  wire logic [2:0] addr,
  input  wire logic       rd_en,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] rd_data,
  // receive/status side of the serial engine
  input  wire logic [7:0] rx_holding,
  input  wire logic [5:0] int_source,
  input  wire logic [7:0] line_status,
  input  wire logic [3:0] modem_delta,
  input  wire logic [3:0] modem_inputs,
  output logic            rx_read_pulse,
  output logic            line_status_read_pulse,
  output logic            modem_status_read_pulse,
  output logic            int_status_read_pulse,
  // transmit side
  output logic      [7:0] tx_holding,
  output logic            tx_write_pulse,
  // fifo control settings and the two fifo reset strobes
  output logic            fifo_enable,
  output logic            rx_fifo_reset,
  output logic            tx_fifo_reset,
  output logic            dma_mode,
  output logic      [1:0] tx_trigger,
  output logic      [1:0] rx_trigger,
  // configuration outputs
  output logic      [7:0] interrupt_enable,
  output logic      [7:0] line_control,
  output logic      [7:0] modem_control,
  output logic      [7:0] divisor_low,
  output logic      [7:0] divisor_high,
  output logic      [7:0] alternate_function,
  output logic      [7:0] divisor_fraction,
  output logic      [7:0] enhanced_feature,
  output logic      [7:0] resume_char_1,
  output logic      [7:0] resume_char_2,
  output logic      [7:0] pause_char_1,
  output logic      [7:0] pause_char_2,
  output logic      [7:0] scratch
);

  logic                dlab;
  logic                enh_key;
  logic                enh_on;
  logic                div_zero;
  logic                hit;
  logic                wr_hit;
  logic                rd_hit;
  durd_pkg::durd_sel_t sel;
  logic [7:0]          ie_mask;
  logic [7:0]          mc_mask;
  logic [7:0]          fc_mask;
  logic [7:0]          is_mask;
  logic [7:0]          fcr_q;
  logic [7:0]          next_rd_data;

  // this instance serves one channel; chan_id ties it to A or B
  assign hit     = (chan_sel == chan_id);
  assign wr_hit  = hit & wr_en;
  assign rd_hit  = hit & rd_en;
  assign dlab    = line_control[`DURD_LC_DLAB_BIT];
  assign enh_key = (line_control == `DURD_LC_ENH_KEY);
  assign enh_on  = enhanced_feature[`DURD_EF_ENH_BIT];
  assign div_zero = (divisor_low == `DURD_ZERO) && (divisor_high == `DURD_ZERO);

  // enhanced bits masked off unless enabled
  assign ie_mask = enh_on ? 8'hff : ~`DURD_IE_ENH_MASK;
  assign mc_mask = enh_on ? 8'hff : ~`DURD_MC_ENH_MASK;
  assign fc_mask = enh_on ? 8'hff : ~`DURD_FC_ENH_MASK;
  assign is_mask = enh_on ? 8'hff : ~`DURD_IS_ENH_MASK;

  // address decode; the 0xBF key outranks the divisor latch bit
  always_comb begin
    sel = durd_pkg::DURD_SEL_NONE;
    case (addr)
      `DURD_ADDR_0: begin
        if (enh_key)
          sel = durd_pkg::DURD_SEL_NONE;
        else if (!dlab)
          sel = durd_pkg::DURD_SEL_DATA;
        else
          sel = durd_pkg::DURD_SEL_DIV_LOW;
      end
      `DURD_ADDR_1: begin
        if (enh_key)
          sel = durd_pkg::DURD_SEL_NONE;
        else if (!dlab)
          sel = durd_pkg::DURD_SEL_INT_EN;
        else
          sel = durd_pkg::DURD_SEL_DIV_HIGH;
      end
      `DURD_ADDR_2: begin
        if (enh_key)
          sel = durd_pkg::DURD_SEL_ENH_FEAT;
        else if (!dlab)
          sel = durd_pkg::DURD_SEL_INT_FIFO;
        else if (enh_on)
          sel = durd_pkg::DURD_SEL_DIV_FRAC;
        else
          sel = durd_pkg::DURD_SEL_ALT_FN;
      end
      `DURD_ADDR_LCR: sel = durd_pkg::DURD_SEL_STD_UPPER;
      default: begin
        if (enh_key)
          sel = durd_pkg::DURD_SEL_FLOW_CHAR;
        else
          sel = durd_pkg::DURD_SEL_STD_UPPER;
      end
    endcase
  end

  // read mux; revision and id override divisor bytes only on reads
  always_comb begin
    next_rd_data = `DURD_ZERO;
    case (sel)
      durd_pkg::DURD_SEL_DATA:     next_rd_data = rx_holding;
      durd_pkg::DURD_SEL_DIV_LOW:
        next_rd_data = div_zero ? `DURD_REVISION : divisor_low;
      durd_pkg::DURD_SEL_DIV_HIGH:
        next_rd_data = div_zero ? `DURD_DEVICE_ID : divisor_high;
      durd_pkg::DURD_SEL_INT_EN:   next_rd_data = interrupt_enable & ie_mask;
      durd_pkg::DURD_SEL_INT_FIFO:
        next_rd_data = {fcr_q[0], fcr_q[0], int_source & is_mask[5:0]};
      durd_pkg::DURD_SEL_ALT_FN:   next_rd_data = alternate_function & `DURD_AF_MASK;
      durd_pkg::DURD_SEL_DIV_FRAC: next_rd_data = divisor_fraction & `DURD_DF_MASK;
      durd_pkg::DURD_SEL_ENH_FEAT: next_rd_data = enhanced_feature;
      durd_pkg::DURD_SEL_STD_UPPER: begin
        case (addr)
          `DURD_ADDR_LCR: next_rd_data = line_control;
          `DURD_ADDR_4:   next_rd_data = modem_control & mc_mask;
          `DURD_ADDR_5:   next_rd_data = line_status;
          `DURD_ADDR_6:   next_rd_data = {modem_inputs, modem_delta};
          default:        next_rd_data = scratch;
        endcase
      end
      durd_pkg::DURD_SEL_FLOW_CHAR: begin
        case (addr)
          `DURD_ADDR_4: next_rd_data = resume_char_1;
          `DURD_ADDR_5: next_rd_data = resume_char_2;
          `DURD_ADDR_6: next_rd_data = pause_char_1;
          default:      next_rd_data = pause_char_2;
        endcase
      end
      default: next_rd_data = `DURD_ZERO;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst)
      rd_data <= `DURD_ZERO;
    else if (rd_hit)
      rd_data <= next_rd_data;
  end

  // one write strobe per storage location; status locations get none,
  // so a host write there is dropped with no side effect
  logic                we_tx;
  logic                we_fifo;
  logic                we_line;
  logic                we_div_low;
  logic                we_div_high;
  logic                we_alt_fn;
  logic                we_div_frac;
  logic                we_int_en;
  logic                we_modem;
  logic                we_scratch;
  logic                we_enh;
  logic                we_resume_1;
  logic                we_resume_2;
  logic                we_pause_1;
  logic                we_pause_2;
  // reads that have a side effect in the engine
  logic                re_rx;
  logic                re_int_status;
  logic                re_line_status;
  logic                re_modem_status;

  assign we_tx       = wr_hit && (sel == durd_pkg::DURD_SEL_DATA);
  assign we_fifo     = wr_hit && (sel == durd_pkg::DURD_SEL_INT_FIFO);
  // address 3 stays line control under the key, else the key could never be left
  assign we_line     = wr_hit && (addr == `DURD_ADDR_LCR);
  assign we_div_low  = wr_hit && (sel == durd_pkg::DURD_SEL_DIV_LOW);
  assign we_div_high = wr_hit && (sel == durd_pkg::DURD_SEL_DIV_HIGH);
  assign we_alt_fn   = wr_hit && (sel == durd_pkg::DURD_SEL_ALT_FN);
  assign we_div_frac = wr_hit && (sel == durd_pkg::DURD_SEL_DIV_FRAC);
  assign we_int_en   = wr_hit && (sel == durd_pkg::DURD_SEL_INT_EN);
  assign we_modem    = wr_hit && (sel == durd_pkg::DURD_SEL_STD_UPPER) && (addr == `DURD_ADDR_4);
  assign we_scratch  = wr_hit && (sel == durd_pkg::DURD_SEL_STD_UPPER) && (addr == `DURD_ADDR_7);
  assign we_enh      = wr_hit && (sel == durd_pkg::DURD_SEL_ENH_FEAT);
  assign we_resume_1 = wr_hit && (sel == durd_pkg::DURD_SEL_FLOW_CHAR) && (addr == `DURD_ADDR_4);
  assign we_resume_2 = wr_hit && (sel == durd_pkg::DURD_SEL_FLOW_CHAR) && (addr == `DURD_ADDR_5);
  assign we_pause_1  = wr_hit && (sel == durd_pkg::DURD_SEL_FLOW_CHAR) && (addr == `DURD_ADDR_6);
  assign we_pause_2  = wr_hit && (sel == durd_pkg::DURD_SEL_FLOW_CHAR) && (addr == `DURD_ADDR_7);
  assign re_rx           = rd_hit && (sel == durd_pkg::DURD_SEL_DATA);
  assign re_int_status   = rd_hit && (sel == durd_pkg::DURD_SEL_INT_FIFO);
  assign re_line_status  = rd_hit && (sel == durd_pkg::DURD_SEL_STD_UPPER) && (addr == `DURD_ADDR_5);
  assign re_modem_status = rd_hit && (sel == durd_pkg::DURD_SEL_STD_UPPER) && (addr == `DURD_ADDR_6);

  // read side effects, one-cycle pulses for the engine
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_read_pulse           <= 1'b0;
      line_status_read_pulse  <= 1'b0;
      modem_status_read_pulse <= 1'b0;
      int_status_read_pulse   <= 1'b0;
    end else begin
      rx_read_pulse           <= re_rx;
      int_status_read_pulse   <= re_int_status;
      line_status_read_pulse  <= re_line_status;
      modem_status_read_pulse <= re_modem_status;
    end
  end

  // transmit holding, write-only
  always_ff @(posedge clk) begin
    if (srst)
      tx_holding <= `DURD_RST_REG;
    else if (we_tx)
      tx_holding <= wr_data;
  end

  // load strobe for the engine, one cycle after the write
  always_ff @(posedge clk) begin
    if (srst)
      tx_write_pulse <= 1'b0;
    else
      tx_write_pulse <= we_tx;
  end

  // fifo control settings
  always_ff @(posedge clk) begin
    if (srst)
      fcr_q <= `DURD_RST_FC;
    else if (we_fifo)
      fcr_q <= wr_data & fc_mask;
  end

  // fifo reset bits self-clear after one cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_fifo_reset <= 1'b0;
      tx_fifo_reset <= 1'b0;
    end else begin
      rx_fifo_reset <= we_fifo & wr_data[1];
      tx_fifo_reset <= we_fifo & wr_data[2];
    end
  end

  assign fifo_enable = fcr_q[0];
  assign dma_mode    = fcr_q[3];
  // tx trigger needs enhanced mode; stored value already masked
  assign tx_trigger  = fcr_q[5:4] & fc_mask[5:4];
  assign rx_trigger  = fcr_q[7:6];

  // line control, always reachable at address 3, including under the key value
  always_ff @(posedge clk) begin
    if (srst)
      line_control <= `DURD_RST_LC;
    else if (we_line)
      line_control <= wr_data;
  end

  // baud divisor bytes; revision and id codes only alias them on reads
  always_ff @(posedge clk) begin
    if (srst)
      divisor_low <= `DURD_RST_REG;
    else if (we_div_low)
      divisor_low <= wr_data;
  end

  always_ff @(posedge clk) begin
    if (srst)
      divisor_high <= `DURD_RST_REG;
    else if (we_div_high)
      divisor_high <= wr_data;
  end

  // reserved and unused bits are never stored, so they read back as zero
  always_ff @(posedge clk) begin
    if (srst)
      alternate_function <= `DURD_RST_REG;
    else if (we_alt_fn)
      alternate_function <= wr_data & `DURD_AF_MASK;
  end

  always_ff @(posedge clk) begin
    if (srst)
      divisor_fraction <= `DURD_RST_REG;
    else if (we_div_frac)
      divisor_fraction <= wr_data & `DURD_DF_MASK;
  end

  // enhanced bits are dropped at write time unless enhanced mode is on
  always_ff @(posedge clk) begin
    if (srst)
      interrupt_enable <= `DURD_RST_IE;
    else if (we_int_en)
      interrupt_enable <= wr_data & ie_mask;
  end

  always_ff @(posedge clk) begin
    if (srst)
      modem_control <= `DURD_RST_MC;
    else if (we_modem)
      modem_control <= wr_data & mc_mask;
  end

  always_ff @(posedge clk) begin
    if (srst)
      scratch <= `DURD_RST_REG;
    else if (we_scratch)
      scratch <= wr_data;
  end

  // enhanced registers behind the key value
  always_ff @(posedge clk) begin
    if (srst)
      enhanced_feature <= `DURD_RST_REG;
    else if (we_enh)
      enhanced_feature <= wr_data;
  end

  always_ff @(posedge clk) begin
    if (srst)
      resume_char_1 <= `DURD_RST_REG;
    else if (we_resume_1)
      resume_char_1 <= wr_data;
  end

  always_ff @(posedge clk) begin
    if (srst)
      resume_char_2 <= `DURD_RST_REG;
    else if (we_resume_2)
      resume_char_2 <= wr_data;
  end

  always_ff @(posedge clk) begin
    if (srst)
      pause_char_1 <= `DURD_RST_REG;
    else if (we_pause_1)
      pause_char_1 <= wr_data;
  end

  always_ff @(posedge clk) begin
    if (srst)
      pause_char_2 <= `DURD_RST_REG;
    else if (we_pause_2)
      pause_char_2 <= wr_data;
  end

endmodule

// ---- core/durd_params.svh ----
`ifndef DURD_PARAMS_SVH
`define DURD_PARAMS_SVH
// register addresses (a2..a0)
`define DURD_ADDR_0        3'h0
`define DURD_ADDR_1        3'h1
`define DURD_ADDR_2        3'h2
`define DURD_ADDR_LCR      3'h3
`define DURD_ADDR_4        3'h4
`define DURD_ADDR_5        3'h5
`define DURD_ADDR_6        3'h6
`define DURD_ADDR_7        3'h7
// line control
`define DURD_LC_ENH_KEY    8'hbf
`define DURD_LC_DLAB_BIT   7
// enhanced feature
`define DURD_EF_ENH_BIT    4
// enhanced-only masks, then implemented-bit masks and zero
`define DURD_IE_ENH_MASK   8'hf0
`define DURD_IS_ENH_MASK   8'h30
`define DURD_FC_ENH_MASK   8'h30
`define DURD_MC_ENH_MASK   8'he0
`define DURD_AF_MASK       8'h07
`define DURD_DF_MASK       8'h3f
`define DURD_ZERO          8'h00
// reset values
`define DURD_RST_LC        8'h00
`define DURD_RST_MC        8'h00
`define DURD_RST_IE        8'h00
`define DURD_RST_FC        8'h00
`define DURD_RST_REG       8'h00
// identity codes, values arbitrary
`define DURD_REVISION      8'h01
`define DURD_DEVICE_ID     8'h5a
`endif

// ---- core/durd_pkg.sv ----
package durd_pkg;
  typedef enum logic [3:0] {
    DURD_SEL_NONE,
    DURD_SEL_DATA,
    DURD_SEL_DIV_LOW,
    DURD_SEL_DIV_HIGH,
    DURD_SEL_REVISION,
    DURD_SEL_DEVICE_ID,
    DURD_SEL_INT_EN,
    DURD_SEL_INT_FIFO,
    DURD_SEL_ALT_FN,
    DURD_SEL_DIV_FRAC,
    DURD_SEL_ENH_FEAT,
    DURD_SEL_STD_UPPER,
    DURD_SEL_FLOW_CHAR
  } durd_sel_t;
endpackage

// ---- verif/durd_regs_checker.sv ----
`timescale 1ns/1ns
`include "durd_params.svh"
module durd_regs_checker (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       chan_sel,
  input wire logic       chan_id,
  input wire logic [2:0] addr,
  input wire logic       rd_en,
  input wire logic       wr_en,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic [7:0] rx_holding,
  input wire logic [7:0] line_status,
  input wire logic [3:0] modem_delta,
  input wire logic [3:0] modem_inputs,
  input wire logic       rx_read_pulse,
  input wire logic       line_status_read_pulse,
  input wire logic       modem_status_read_pulse,
  input wire logic       int_status_read_pulse,
  input wire logic       fifo_enable,
  input wire logic       dma_mode,
  input wire logic [1:0] tx_trigger,
  input wire logic [1:0] rx_trigger,
  input wire logic [7:0] tx_holding,
  input wire logic       tx_write_pulse,
  input wire logic       rx_fifo_reset,
  input wire logic       tx_fifo_reset,
  input wire logic [7:0] interrupt_enable,
  input wire logic [7:0] line_control,
  input wire logic [7:0] divisor_low,
  input wire logic [7:0] divisor_high,
  input wire logic [7:0] enhanced_feature,
  input wire logic [7:0] scratch
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic hit;
  logic std;
  logic rd0;
  assign hit = chan_sel == chan_id;
  assign std = line_control != `DURD_LC_ENH_KEY;
  assign rd0 = !line_control[7];
  a_tx_write_load: assert property (wr_en && hit && addr == 3'h0 && rd0 |=>
    tx_write_pulse && tx_holding == $past(wr_data)) else $error("tx holding load wrong");
  a_rx_read_data: assert property (rd_en && hit && addr == 3'h0 && rd0 |=>
    rx_read_pulse && rd_data == $past(rx_holding)) else $error("rx holding read wrong");
  a_scratch_write: assert property (wr_en && hit && addr == 3'h7 && std |=>
    scratch == $past(wr_data)) else $error("scratch write wrong");
  a_other_channel: assert property ((wr_en || rd_en) && !hit |=> $stable(scratch) &&
    $stable(line_control) && $stable(rd_data) && !tx_write_pulse) else $error("other channel access took effect");
  a_line_status: assert property (rd_en && hit && addr == 3'h5 && std |=>
    rd_data == $past(line_status)) else $error("line status read wrong");
  a_modem_status: assert property (rd_en && hit && addr == 3'h6 && std |=>
    rd_data == {$past(modem_inputs), $past(modem_delta)}) else $error("modem status read wrong");
  a_ident_read: assert property (rd_en && hit && addr == 3'h1 && !rd0 && std && divisor_low == 8'h00 &&
    divisor_high == 8'h00 |=> rd_data == `DURD_DEVICE_ID) else $error("device id read wrong");
  a_fifo_reset_pulse: assert property (wr_en && hit && addr == 3'h2 && rd0 |=>
    rx_fifo_reset == $past(wr_data[1]) && tx_fifo_reset == $past(wr_data[2])) else $error("fifo reset pulse wrong");
  a_enable_mask: assert property (wr_en && hit && addr == 3'h1 && rd0 |=>
    interrupt_enable == ($past(wr_data) & (enhanced_feature[4] ? 8'hff : 8'h0f))) else $error("enable mask wrong");
  a_status_pulses: assert property (rd_en && hit && std && (addr == 3'h5 || addr == 3'h6) |=>
    line_status_read_pulse == ($past(addr) == 3'h5) && modem_status_read_pulse == ($past(addr) == 3'h6))
    else $error("status read pulse wrong");
  a_int_status_read: assert property (rd_en && hit && addr == 3'h2 && rd0 |=>
    int_status_read_pulse && rd_data[7:6] == {2{fifo_enable}}) else $error("interrupt status read wrong");
  a_fifo_fields: assert property (wr_en && hit && addr == 3'h2 && rd0 |=> fifo_enable == $past(wr_data[0]) &&
    dma_mode == $past(wr_data[3]) && rx_trigger == $past(wr_data[7:6]) &&
    tx_trigger == ($past(wr_data[5:4]) & {2{enhanced_feature[4]}})) else $error("fifo control fields wrong");
  a_revision_read: assert property (rd_en && hit && addr == 3'h0 && !rd0 && std && divisor_low == 8'h00 &&
    divisor_high == 8'h00 |=> rd_data == `DURD_REVISION) else $error("revision read wrong");
endmodule
bind durd_regs durd_regs_checker chk (.*);

// ---- verif/durd_host.sv ----
`timescale 1ns/1ns
module durd_host (
  input wire logic       clk,
  output logic           chan_sel,
  output logic     [2:0] addr,
  output logic           rd_en,
  output logic           wr_en,
  output logic     [7:0] wr_data
);
  initial begin
    chan_sel = 1'b0;
    addr = 3'h0;
    rd_en = 1'b0;
    wr_en = 1'b0;
    wr_data = 8'h00;
  end
  // strobe held one cycle, then one idle cycle; qualifiers held over the taking edge
  task automatic acc(input logic ch, input logic [2:0] a, input logic wr, input logic [7:0] d);
    @(negedge clk);
    chan_sel <= ch;
    addr <= a;
    wr_en <= wr;
    rd_en <= !wr;
    wr_data <= d;
    @(negedge clk);
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    // released bus must not look like stale data
    wr_data <= ~d;
  endtask
endmodule

// ---- verif/testbench.sv ----
`timescale 1ns/1ns
`include "durd_params.svh"
module testbench;
  logic        clk;
  logic        srst;
  logic        chan_sel;
  logic  [2:0] addr;
  logic        rd_en;
  logic        wr_en;
  logic  [7:0] wr_data;
  logic  [7:0] rd_data;
  logic  [7:0] rd_data_b;
  logic  [7:0] rx_holding;
  logic  [5:0] int_source;
  logic  [7:0] line_status;
  logic  [3:0] modem_delta;
  logic  [3:0] modem_inputs;
  logic  [7:0] tx_holding;
  logic  [7:0] d;
  logic [31:0] seed;
  int          num_errors;
  int          check_count;
  durd_host host (.clk(clk), .chan_sel(chan_sel), .addr(addr), .rd_en(rd_en), .wr_en(wr_en), .wr_data(wr_data));
  durd_regs DUT (.clk(clk), .srst(srst), .chan_sel(chan_sel), .chan_id(1'b0), .addr(addr), .rd_en(rd_en),
    .wr_en(wr_en), .wr_data(wr_data), .rd_data(rd_data), .rx_holding(rx_holding), .int_source(int_source),
    .line_status(line_status), .modem_delta(modem_delta), .modem_inputs(modem_inputs), .rx_read_pulse(),
    .line_status_read_pulse(), .modem_status_read_pulse(), .int_status_read_pulse(), .tx_holding(tx_holding),
    .tx_write_pulse(), .fifo_enable(), .rx_fifo_reset(), .tx_fifo_reset(), .dma_mode(), .tx_trigger(),
    .rx_trigger(), .interrupt_enable(), .line_control(), .modem_control(), .divisor_low(), .divisor_high(),
    .alternate_function(), .divisor_fraction(), .enhanced_feature(), .resume_char_1(), .resume_char_2(),
    .pause_char_1(), .pause_char_2(), .scratch());
  // second channel on the same bus, strapped as channel B
  durd_regs DUT_B (.clk(clk), .srst(srst), .chan_sel(chan_sel), .chan_id(1'b1), .addr(addr), .rd_en(rd_en),
    .wr_en(wr_en), .wr_data(wr_data), .rd_data(rd_data_b), .rx_holding(rx_holding), .int_source(int_source),
    .line_status(line_status), .modem_delta(modem_delta), .modem_inputs(modem_inputs), .rx_read_pulse(),
    .line_status_read_pulse(), .modem_status_read_pulse(), .int_status_read_pulse(), .tx_holding(),
    .tx_write_pulse(), .fifo_enable(), .rx_fifo_reset(), .tx_fifo_reset(), .dma_mode(), .tx_trigger(),
    .rx_trigger(), .interrupt_enable(), .line_control(), .modem_control(), .divisor_low(), .divisor_high(),
    .alternate_function(), .divisor_fraction(), .enhanced_feature(), .resume_char_1(), .resume_char_2(),
    .pause_char_1(), .pause_char_2(), .scratch());
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    host.acc(1'b0, a, 1'b1, v);
  endtask
  // extra edge so either read latency reading is settled
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    host.acc(1'b0, a, 1'b0, 8'h00);
    @(negedge clk);
    cmp(rd_data, exp);
  endtask
  initial begin
    #(40 * 4000);
    num_errors++;
    end_sim();
  end
  initial begin
    srst = 1'b1;
    seed = 32'h30e8_69dc;
    {rx_holding, int_source, line_status, modem_delta, modem_inputs} = 30'h0000_0000;
    repeat (3) @(negedge clk);
    srst <= 1'b0;
    rd(3'h3, `DURD_RST_LC);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      d = (i == 0) ? 8'hff : seed[31:24];
      rx_holding <= seed[7:0];
      line_status <= seed[15:8];
      int_source <= seed[21:16];
      modem_delta <= seed[25:22];
      modem_inputs <= seed[29:26];
      wr(3'h7, d);
      rd(3'h7, d);
      wr(3'h1, d);
      rd(3'h1, d & 8'h0f);
      wr(3'h4, d);
      rd(3'h4, d & 8'h1f);
      wr(3'h0, d);
      @(negedge clk);
      cmp(tx_holding, d);
      rd(3'h0, seed[7:0]);
      wr(3'h5, ~d);
      rd(3'h5, seed[15:8]);
      rd(3'h6, seed[29:22]);
      wr(3'h2, d | 8'h01);
      rd(3'h2, {4'hc, seed[19:16]});
      host.acc(1'b1, 3'h7, 1'b1, ~d);
      host.acc(1'b1, 3'h7, 1'b0, 8'h00);
      @(negedge clk);
      cmp(rd_data_b, ~d);
      rd(3'h7, d);
    end
    wr(3'h3, 8'h80);
    rd(3'h3, 8'h80);
    rd(3'h0, `DURD_REVISION);
    rd(3'h1, `DURD_DEVICE_ID);
    wr(3'h0, 8'h5c);
    wr(3'h1, 8'ha3);
    rd(3'h0, 8'h5c);
    rd(3'h1, 8'ha3);
    wr(3'h2, 8'hff);
    rd(3'h2, 8'h07);
    wr(3'h3, 8'hbf);
    wr(3'h2, 8'h10);
    rd(3'h2, 8'h10);
    for (int a = 4; a < 8; a++) begin
      seed = xs(seed);
      wr(a[2:0], seed[7:0]);
      rd(a[2:0], seed[7:0]);
    end
    wr(3'h3, 8'h80);
    wr(3'h2, 8'hff);
    rd(3'h2, 8'h3f);
    wr(3'h3, 8'h00);
    wr(3'h1, 8'hff);
    rd(3'h1, 8'hff);
    wr(3'h4, 8'hff);
    rd(3'h4, 8'hff);
    end_sim();
  end
endmodule
